// >>> design/incr_shift_pkg.sv
package incr_shift_pkg;

	// bus geometry
	localparam int ADDR_W = 8; // byte address bits decoded by the slave
	localparam int BUS_W = 32; // ahb data width
	localparam int HTRANS_ACTIVE_BIT = 1; // set for nonseq and seq

	// datapath geometry
	localparam int DATA_W = 8; // accumulator and file register width
	localparam int FADDR_W = 7; // file address 0..127
	localparam int FILE_DEPTH = 128; // number of file registers
	localparam int LIT_W = 11; // branch immediate 0..2047
	localparam int PC_W = 15; // program counter width
	localparam int LATCH_W = 7; // high address latch width
	localparam int LATCH_HI_MSB = 6; // latch bits that feed pc<14:11>
	localparam int LATCH_HI_LSB = 3;
	localparam int CYC_W = 16; // executed cycle counter width

	// register byte offsets
	localparam logic [ADDR_W-1:0] CMD_OFS = 8'h00; // command, write starts it
	localparam logic [ADDR_W-1:0] ACC_OFS = 8'h04; // accumulator
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08; // carry, zero, busy
	localparam logic [ADDR_W-1:0] PC_OFS = 8'h0C; // program counter
	localparam logic [ADDR_W-1:0] LATCH_OFS = 8'h10; // high address latch
	localparam logic [ADDR_W-1:0] FIDX_OFS = 8'h14; // file access index
	localparam logic [ADDR_W-1:0] FDATA_OFS = 8'h18; // file data at index
	localparam logic [ADDR_W-1:0] CYCLES_OFS = 8'h1C; // executed cycles

	// command register fields
	localparam int CMD_OP_LSB = 0; // operation code, 3 bits
	localparam int CMD_OP_W = 3;
	localparam int CMD_DEST_BIT = 3; // 0 accumulator, 1 file register
	localparam int CMD_FADDR_LSB = 4; // file address, 7 bits
	localparam int CMD_LIT_LSB = 16; // literal, 11 bits

	// status register fields
	localparam int STAT_CARRY_BIT = 0;
	localparam int STAT_ZERO_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;

	// reset values and steps
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
	localparam logic [PC_W-1:0] PC_SKIP_STEP = 15'h0002;
	localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
	localparam logic [DATA_W-1:0] INC_STEP = 8'h01;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [CYC_W-1:0] CYC_STEP = 16'h0001;

	// operations
	typedef enum logic [2:0] {
		OP_INCREMENT_SKIP_ZERO = 3'b000,
		OP_JUMP_ABSOLUTE = 3'b001,
		OP_OR_LITERAL_ACCUMULATOR = 3'b010,
		OP_INCREMENT_FILE = 3'b011,
		OP_OR_ACCUMULATOR_FILE = 3'b100,
		OP_SHIFT_LEFT_FILE = 3'b101
	} op_t;

	// execution sequencer
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_SLOT = 2'b10
	} exec_state_t;

endpackage

// >>> design/increment_or_shift_branch_ops.sv
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps

module increment_or_shift_branch_ops (
	input wire logic core_clk_i, // core clock, 20 MHz
	input wire logic rstn_i, // asynchronous reset, active low
	input wire logic hsel_i, // ahb slave select
	input wire logic [incr_shift_pkg::ADDR_W-1:0] haddr_i, // ahb byte address
	input wire logic [1:0] htrans_i, // ahb transfer type
	input wire logic hwrite_i, // ahb write
	input wire logic [2:0] hsize_i, // ahb size, word only
	input wire logic [incr_shift_pkg::BUS_W-1:0] hwdata_i, // ahb write data
	input wire logic hready_i, // ahb bus ready
	output logic [incr_shift_pkg::BUS_W-1:0] hrdata_o, // ahb read data
	output logic hreadyout_o, // ahb slave ready
	output logic hresp_o, // ahb response, always okay
	output logic [incr_shift_pkg::PC_W-1:0] pc_o, // program counter
	output logic [incr_shift_pkg::DATA_W-1:0] acc_o, // accumulator
	output logic busy_o // operation in progress
);

	// reset synchroniser
	logic rst_meta_n; // first stage, read only by second
	logic rst_n; // released reset for the design

	// bus data phase
	logic dp_active; // data phase pending
	logic dp_write; // pending transfer is a write
	logic [incr_shift_pkg::ADDR_W-1:0] dp_addr; // pending address
	logic rdata_ok; // read data already loaded
	logic addr_take; // address phase accepted
	logic wr_fire; // write data committed this edge

	// architectural state
	incr_shift_pkg::exec_state_t state; // sequencer state
	incr_shift_pkg::op_t cmd_op; // latched operation
	logic cmd_dest; // latched destination select
	logic [incr_shift_pkg::FADDR_W-1:0] cmd_faddr; // latched file address
	logic [incr_shift_pkg::LIT_W-1:0] cmd_lit; // latched literal
	logic [incr_shift_pkg::DATA_W-1:0] acc; // accumulator
	logic carry; // carry flag
	logic zero; // zero flag
	logic [incr_shift_pkg::PC_W-1:0] pc; // program counter
	logic [incr_shift_pkg::LATCH_W-1:0] hi_latch; // program_counter_high_latch
	logic [incr_shift_pkg::FADDR_W-1:0] fidx; // file access index
	logic [incr_shift_pkg::CYC_W-1:0] cyc_count; // executed cycles
	logic [incr_shift_pkg::DATA_W-1:0] file_mem [0:incr_shift_pkg::FILE_DEPTH-1]; // file

	// alu results
	logic [incr_shift_pkg::DATA_W-1:0] alu_result; // result byte
	logic alu_carry; // next carry
	logic alu_carry_upd; // carry written
	logic alu_zero_upd; // zero written
	logic alu_zero; // result is zero
	logic alu_write; // result has a destination
	logic alu_acc_only; // accumulator only
	logic alu_skip; // idle slot follows
	logic alu_jump; // absolute branch
	logic exec_now; // executing this cycle
	logic to_acc; // result steered to accumulator
	logic to_file; // result steered to file register

	// word-aligned register decode
	function automatic logic reg_hit(input logic [incr_shift_pkg::ADDR_W-1:0] a,
			input logic [incr_shift_pkg::ADDR_W-1:0] ofs);
		reg_hit = (a[incr_shift_pkg::ADDR_W-1:2] == ofs[incr_shift_pkg::ADDR_W-1:2]);
	endfunction

	// read multiplexer, unmapped reads give zero
	function automatic logic [incr_shift_pkg::BUS_W-1:0] read_mux(
			input logic [incr_shift_pkg::ADDR_W-1:0] a);
		read_mux = '0;
		if (reg_hit(a, incr_shift_pkg::CMD_OFS)) begin
			read_mux[incr_shift_pkg::CMD_OP_LSB +: incr_shift_pkg::CMD_OP_W] = cmd_op;
			read_mux[incr_shift_pkg::CMD_DEST_BIT] = cmd_dest;
			read_mux[incr_shift_pkg::CMD_FADDR_LSB +: incr_shift_pkg::FADDR_W] = cmd_faddr;
			read_mux[incr_shift_pkg::CMD_LIT_LSB +: incr_shift_pkg::LIT_W] = cmd_lit;
		end else if (reg_hit(a, incr_shift_pkg::ACC_OFS)) begin
			read_mux[incr_shift_pkg::DATA_W-1:0] = acc;
		end else if (reg_hit(a, incr_shift_pkg::STATUS_OFS)) begin
			read_mux[incr_shift_pkg::STAT_CARRY_BIT] = carry;
			read_mux[incr_shift_pkg::STAT_ZERO_BIT] = zero;
			read_mux[incr_shift_pkg::STAT_BUSY_BIT] = (state != incr_shift_pkg::ST_IDLE);
		end else if (reg_hit(a, incr_shift_pkg::PC_OFS)) begin
			read_mux[incr_shift_pkg::PC_W-1:0] = pc;
		end else if (reg_hit(a, incr_shift_pkg::LATCH_OFS)) begin
			read_mux[incr_shift_pkg::LATCH_W-1:0] = hi_latch;
		end else if (reg_hit(a, incr_shift_pkg::FIDX_OFS)) begin
			read_mux[incr_shift_pkg::FADDR_W-1:0] = fidx;
		end else if (reg_hit(a, incr_shift_pkg::FDATA_OFS)) begin
			read_mux[incr_shift_pkg::DATA_W-1:0] = file_mem[fidx];
		end else if (reg_hit(a, incr_shift_pkg::CYCLES_OFS)) begin
			read_mux[incr_shift_pkg::CYC_W-1:0] = cyc_count;
		end
	endfunction

	// two-stage reset release
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// bus handshake: stall while executing, one wait state on reads
	assign busy_o = (state != incr_shift_pkg::ST_IDLE);
	assign hreadyout_o = !(dp_active && (busy_o || (!dp_write && !rdata_ok)));
	assign hresp_o = 1'b0;
	assign addr_take = hsel_i && htrans_i[incr_shift_pkg::HTRANS_ACTIVE_BIT] && hready_i;
	assign wr_fire = dp_active && dp_write && hreadyout_o;

	// data phase tracking
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dp_active <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= '0;
		end else if (addr_take) begin
			dp_active <= 1'b1;
			dp_write <= hwrite_i;
			dp_addr <= haddr_i;
		end else if (hreadyout_o) begin
			dp_active <= 1'b0;
		end
	end

	// read data register, loaded once the core is idle
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_o <= '0;
			rdata_ok <= 1'b0;
		end else if (addr_take) begin
			rdata_ok <= 1'b0;
		end else if (dp_active && !dp_write && !busy_o && !rdata_ok) begin
			hrdata_o <= read_mux(dp_addr);
			rdata_ok <= 1'b1;
		end
	end

	// operand path into the alu
	increment_shift_alu u_alu (
		.op_i(cmd_op),
		.acc_i(acc),
		.file_i(file_mem[cmd_faddr]),
		.lit_i(cmd_lit[incr_shift_pkg::DATA_W-1:0]),
		.carry_i(carry),
		.result_o(alu_result),
		.carry_o(alu_carry),
		.carry_upd_o(alu_carry_upd),
		.zero_upd_o(alu_zero_upd),
		.zero_o(alu_zero),
		.write_o(alu_write),
		.acc_only_o(alu_acc_only),
		.skip_o(alu_skip),
		.jump_o(alu_jump)
	);

	// destination steering
	assign exec_now = (state == incr_shift_pkg::ST_EXEC);
	assign to_acc = exec_now && alu_write && (alu_acc_only || !cmd_dest);
	assign to_file = exec_now && alu_write && !alu_acc_only && cmd_dest;

	// command capture and sequencer
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= incr_shift_pkg::ST_IDLE;
			cmd_op <= incr_shift_pkg::OP_INCREMENT_SKIP_ZERO;
			cmd_dest <= 1'b0;
			cmd_faddr <= '0;
			cmd_lit <= '0;
		end else begin
			case (state)
				incr_shift_pkg::ST_IDLE: begin
					// a command write starts the operation
					if (wr_fire && reg_hit(dp_addr, incr_shift_pkg::CMD_OFS)) begin
						cmd_op <= incr_shift_pkg::op_t'(
							hwdata_i[incr_shift_pkg::CMD_OP_LSB +: incr_shift_pkg::CMD_OP_W]);
						cmd_dest <= hwdata_i[incr_shift_pkg::CMD_DEST_BIT];
						cmd_faddr <= hwdata_i[incr_shift_pkg::CMD_FADDR_LSB +:
							incr_shift_pkg::FADDR_W];
						cmd_lit <= hwdata_i[incr_shift_pkg::CMD_LIT_LSB +: incr_shift_pkg::LIT_W];
						state <= incr_shift_pkg::ST_EXEC;
					end
				end
				incr_shift_pkg::ST_EXEC: begin
					// second cycle only for a skip or a branch
					if (alu_skip || alu_jump) begin
						state <= incr_shift_pkg::ST_SLOT;
					end else begin
						state <= incr_shift_pkg::ST_IDLE;
					end
				end
				incr_shift_pkg::ST_SLOT: begin
					// idle slot: only the cycle counter advances
					state <= incr_shift_pkg::ST_IDLE;
				end
				default: begin
					state <= incr_shift_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// accumulator
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			acc <= incr_shift_pkg::ACC_RST;
		end else if (to_acc) begin
			acc <= alu_result;
		end else if (wr_fire && reg_hit(dp_addr, incr_shift_pkg::ACC_OFS)) begin
			acc <= hwdata_i[incr_shift_pkg::DATA_W-1:0];
		end
	end
	assign acc_o = acc;

	// status flags: only operations that own a flag touch it
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			carry <= 1'b0;
			zero <= 1'b0;
		end else if (exec_now) begin
			if (alu_carry_upd) begin
				carry <= alu_carry;
			end
			if (alu_zero_upd) begin
				zero <= alu_zero;
			end
		end else if (wr_fire && reg_hit(dp_addr, incr_shift_pkg::STATUS_OFS)) begin
			carry <= hwdata_i[incr_shift_pkg::STAT_CARRY_BIT];
			zero <= hwdata_i[incr_shift_pkg::STAT_ZERO_BIT];
		end
	end

	// program counter: step, double step over the slot, or branch target
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pc <= incr_shift_pkg::PC_RST;
		end else if (exec_now) begin
			if (alu_jump) begin
				pc <= {hi_latch[incr_shift_pkg::LATCH_HI_MSB:incr_shift_pkg::LATCH_HI_LSB],
					cmd_lit};
			end else if (alu_skip) begin
				pc <= pc + incr_shift_pkg::PC_SKIP_STEP;
			end else begin
				pc <= pc + incr_shift_pkg::PC_STEP;
			end
		end else if (wr_fire && reg_hit(dp_addr, incr_shift_pkg::PC_OFS)) begin
			pc <= hwdata_i[incr_shift_pkg::PC_W-1:0];
		end
	end
	assign pc_o = pc;

	// high address latch and file index, software owned
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hi_latch <= incr_shift_pkg::LATCH_RST;
			fidx <= '0;
		end else if (wr_fire) begin
			if (reg_hit(dp_addr, incr_shift_pkg::LATCH_OFS)) begin
				hi_latch <= hwdata_i[incr_shift_pkg::LATCH_W-1:0];
			end
			if (reg_hit(dp_addr, incr_shift_pkg::FIDX_OFS)) begin
				fidx <= hwdata_i[incr_shift_pkg::FADDR_W-1:0];
			end
		end
	end

	// file registers: write-back from execution or bus
	always_ff @(posedge core_clk_i) begin
		if (to_file) begin
			file_mem[cmd_faddr] <= alu_result;
		end else if (wr_fire && reg_hit(dp_addr, incr_shift_pkg::FDATA_OFS)) begin
			file_mem[fidx] <= hwdata_i[incr_shift_pkg::DATA_W-1:0];
		end
	end

	// count every execution cycle, idle slots included
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cyc_count <= '0;
		end else if (state != incr_shift_pkg::ST_IDLE) begin
			cyc_count <= cyc_count + incr_shift_pkg::CYC_STEP;
		end
	end

endmodule

// >>> design/increment_shift_alu.sv
`timescale 1ns/1ps

// combinational result and flag logic for one operation
module increment_shift_alu (
	input wire incr_shift_pkg::op_t op_i, // operation
	input wire logic [incr_shift_pkg::DATA_W-1:0] acc_i, // accumulator
	input wire logic [incr_shift_pkg::DATA_W-1:0] file_i, // addressed file register
	input wire logic [incr_shift_pkg::DATA_W-1:0] lit_i, // 8-bit literal
	input wire logic carry_i, // present carry
	output logic [incr_shift_pkg::DATA_W-1:0] result_o, // 8-bit result
	output logic carry_o, // next carry
	output logic carry_upd_o, // carry is written
	output logic zero_upd_o, // zero flag is written
	output logic zero_o, // result equals zero
	output logic write_o, // result goes to a destination
	output logic acc_only_o, // destination is always the accumulator
	output logic skip_o, // next instruction becomes idle slot
	output logic jump_o // absolute branch
);

	// zero test shared by flag update and skip decision
	assign zero_o = (result_o == incr_shift_pkg::ZERO_BYTE);

	// per-operation result and flag enables
	always_comb begin
		result_o = acc_i;
		carry_o = carry_i;
		carry_upd_o = 1'b0;
		zero_upd_o = 1'b0;
		write_o = 1'b0;
		acc_only_o = 1'b0;
		jump_o = 1'b0;
		case (op_i)
			incr_shift_pkg::OP_INCREMENT_SKIP_ZERO: begin
				// flags untouched
				result_o = file_i + incr_shift_pkg::INC_STEP;
				write_o = 1'b1;
			end
			incr_shift_pkg::OP_JUMP_ABSOLUTE: begin
				// no data result, no flags
				jump_o = 1'b1;
			end
			incr_shift_pkg::OP_OR_LITERAL_ACCUMULATOR: begin
				result_o = acc_i | lit_i;
				write_o = 1'b1;
				acc_only_o = 1'b1;
				zero_upd_o = 1'b1;
			end
			incr_shift_pkg::OP_INCREMENT_FILE: begin
				result_o = file_i + incr_shift_pkg::INC_STEP;
				write_o = 1'b1;
				zero_upd_o = 1'b1;
			end
			incr_shift_pkg::OP_OR_ACCUMULATOR_FILE: begin
				result_o = acc_i | file_i;
				write_o = 1'b1;
				zero_upd_o = 1'b1;
			end
			incr_shift_pkg::OP_SHIFT_LEFT_FILE: begin
				// msb into carry, zero into lsb
				result_o = {file_i[incr_shift_pkg::DATA_W-2:0], 1'b0};
				carry_o = file_i[incr_shift_pkg::DATA_W-1];
				carry_upd_o = 1'b1;
				zero_upd_o = 1'b1;
				write_o = 1'b1;
			end
			default: begin
				// unknown code: no effect
				result_o = acc_i;
			end
		endcase
	end

	// skip only for increment-and-skip with a zero sum
	assign skip_o = (op_i == incr_shift_pkg::OP_INCREMENT_SKIP_ZERO) && zero_o;

endmodule

// >>> sim/increment_or_shift_branch_ops_bench.sv
`timescale 1ns/1ps

// drives the register bus and checks each operation's results
module increment_or_shift_branch_ops_bench;
	logic core_clk_i = 1'b0; // 20 MHz clock
	logic rstn_i = 1'b0; // reset, active low
	logic hsel_i = 1'b0; // select
	logic [7:0] haddr_i = 8'h00; // address
	logic [1:0] htrans_i = 2'h0; // transfer type
	logic hwrite_i = 1'b0; // write
	logic [2:0] hsize_i = 3'h2; // word
	logic [31:0] hwdata_i = 32'h0; // write data
	wire logic [31:0] hrdata_o; // read data
	wire logic hreadyout_o; // ready, also the bus ready
	wire logic hresp_o; // response
	wire logic [14:0] pc_o; // program counter
	wire logic [7:0] acc_o; // accumulator
	wire logic busy_o; // busy
	int err_total = 0; // mismatches
	int num_checks = 0; // comparisons
	always #25 core_clk_i = ~core_clk_i;
	increment_or_shift_branch_ops dut (.core_clk_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
		.hresp_o, .pc_o, .acc_o, .busy_o);
	// verdict and end of run
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// wait, bounded, for ready sampled high at a rising edge
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 40);
		if (hreadyout_o !== 1'b1) begin
			chk({31'h0, hreadyout_o}, 32'h1);
			end_of_test();
		end
	endtask
	// one single transfer: address phase, then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		wait_rdy();
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		wait_rdy();
		rd = hrdata_o;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		chk(d, e);
	endtask
	// file register access through index and data
	task fset(input logic [6:0] i, input logic [7:0] v);
		wr(incr_shift_pkg::FIDX_OFS, {25'h0, i});
		wr(incr_shift_pkg::FDATA_OFS, {24'h0, v});
	endtask
	task fchk(input logic [6:0] i, input logic [7:0] e);
		wr(incr_shift_pkg::FIDX_OFS, {25'h0, i});
		rchk(incr_shift_pkg::FDATA_OFS, {24'h0, e});
	endtask
	// run one operation from pc 0x100 with preset flags, then check cycles, pc, flags
	task exec(input incr_shift_pkg::op_t op, input logic d, input logic [6:0] fa,
		input logic [10:0] lit, input logic [1:0] sp, input logic [1:0] se, input logic [14:0] epc);
		logic [31:0] c0;
		logic [31:0] c1;
		logic [15:0] cyd;
		cyd = (op == incr_shift_pkg::OP_JUMP_ABSOLUTE || epc == 15'h0102) ? 16'h0002 : 16'h0001;
		wr(incr_shift_pkg::PC_OFS, 32'h100);
		wr(incr_shift_pkg::STATUS_OFS, {30'h0, sp});
		bus(1'b0, incr_shift_pkg::CYCLES_OFS, 32'h0, c0);
		wr(incr_shift_pkg::CMD_OFS, {5'h00, lit, 5'h00, fa, d, op});
		bus(1'b0, incr_shift_pkg::CYCLES_OFS, 32'h0, c1);
		chk(c1 - c0, {16'h0, cyd});
		chk({17'h0, pc_o}, {17'h0, epc});
		rchk(incr_shift_pkg::STATUS_OFS, {30'h0, se});
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rchk(incr_shift_pkg::PC_OFS, 32'h0);
		wr(8'h20, 32'hFFFFFFFF);
		rchk(8'h20, 32'h0);
		// increment with skip: zero sum to file, then nonzero sum to accumulator
		fset(7'h05, 8'hFF);
		exec(incr_shift_pkg::OP_INCREMENT_SKIP_ZERO, 1'b1, 7'h05, 11'h0, 2'h1, 2'h1, 15'h0102);
		fchk(7'h05, 8'h00);
		exec(incr_shift_pkg::OP_INCREMENT_SKIP_ZERO, 1'b0, 7'h05, 11'h0, 2'h2, 2'h2, 15'h0101);
		rchk(incr_shift_pkg::ACC_OFS, 32'h01);
		fchk(7'h05, 8'h00);
		// branch: only latch bits 6:3 reach the pc
		wr(incr_shift_pkg::LATCH_OFS, 32'h5A);
		exec(incr_shift_pkg::OP_JUMP_ABSOLUTE, 1'b0, 7'h00, 11'h7FF, 2'h3, 2'h3, 15'h5FFF);
		wr(incr_shift_pkg::LATCH_OFS, 32'h07);
		exec(incr_shift_pkg::OP_JUMP_ABSOLUTE, 1'b1, 7'h00, 11'h000, 2'h0, 2'h0, 15'h0000);
		// or literal: accumulator only, low eight literal bits
		wr(incr_shift_pkg::ACC_OFS, 32'h0);
		exec(incr_shift_pkg::OP_OR_LITERAL_ACCUMULATOR, 1'b1, 7'h7F, 11'h0, 2'h1, 2'h3, 15'h0101);
		exec(incr_shift_pkg::OP_OR_LITERAL_ACCUMULATOR, 1'b1, 7'h7F, 11'h7A5, 2'h2, 2'h0, 15'h0101);
		rchk(incr_shift_pkg::ACC_OFS, 32'hA5);
		// plain increment at the top file address, both destinations
		fset(7'h7F, 8'hFF);
		exec(incr_shift_pkg::OP_INCREMENT_FILE, 1'b0, 7'h7F, 11'h0, 2'h1, 2'h3, 15'h0101);
		rchk(incr_shift_pkg::ACC_OFS, 32'h0);
		fchk(7'h7F, 8'hFF);
		exec(incr_shift_pkg::OP_INCREMENT_FILE, 1'b1, 7'h7F, 11'h0, 2'h0, 2'h2, 15'h0101);
		fchk(7'h7F, 8'h00);
		// or accumulator with file into file
		wr(incr_shift_pkg::ACC_OFS, 32'h0F);
		fset(7'h00, 8'hF0);
		exec(incr_shift_pkg::OP_OR_ACCUMULATOR_FILE, 1'b1, 7'h00, 11'h0, 2'h2, 2'h0, 15'h0101);
		fchk(7'h00, 8'hFF);
		rchk(incr_shift_pkg::ACC_OFS, 32'h0F);
		// left shift: top bit to carry, zero into bit 0
		fset(7'h00, 8'h81);
		exec(incr_shift_pkg::OP_SHIFT_LEFT_FILE, 1'b0, 7'h00, 11'h0, 2'h2, 2'h1, 15'h0101);
		rchk(incr_shift_pkg::ACC_OFS, 32'h02);
		fset(7'h00, 8'h40);
		exec(incr_shift_pkg::OP_SHIFT_LEFT_FILE, 1'b1, 7'h00, 11'h0, 2'h3, 2'h0, 15'h0101);
		fchk(7'h00, 8'h80);
		// unused operation code: one cycle, no result, flags kept
		exec(incr_shift_pkg::op_t'(3'h6), 1'b0, 7'h00, 11'h0, 2'h3, 2'h3, 15'h0101);
		rchk(incr_shift_pkg::ACC_OFS, 32'h02);
		end_of_test();
	end
endmodule

// >>> sim/increment_or_shift_branch_ops_monitor.sv
`timescale 1ns/1ps

// port-level checks of the bus slave and the execution sequencer
module increment_or_shift_branch_ops_monitor (
	input wire logic core_clk_i, // core clock
	input wire logic rstn_i, // reset, active low
	input wire logic hsel_i, // slave select
	input wire logic [incr_shift_pkg::ADDR_W-1:0] haddr_i, // byte address
	input wire logic [1:0] htrans_i, // transfer type
	input wire logic hwrite_i, // write
	input wire logic [2:0] hsize_i, // size
	input wire logic [incr_shift_pkg::BUS_W-1:0] hwdata_i, // write data
	input wire logic hready_i, // bus ready
	input wire logic [incr_shift_pkg::BUS_W-1:0] hrdata_o, // read data
	input wire logic hreadyout_o, // slave ready
	input wire logic hresp_o, // response
	input wire logic [incr_shift_pkg::PC_W-1:0] pc_o, // program counter
	input wire logic [incr_shift_pkg::DATA_W-1:0] acc_o, // accumulator
	input wire logic busy_o // operation running
);
	logic take; // address phase taken at this edge
	logic dph; // data phase open
	logic dwr; // open data phase is a write
	logic dfirst; // first cycle of a data phase
	logic commit; // write data lands at this edge
	assign take = hsel_i & htrans_i[1] & hready_i;
	assign commit = dph & dwr & hreadyout_o;
	// follow the single outstanding transfer
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dph <= 1'b0;
			dwr <= 1'b0;
		end else if (take) begin
			dph <= 1'b1;
			dwr <= hwrite_i;
		end else if (hreadyout_o) begin
			dph <= 1'b0;
		end
	end
	// first data-phase cycle follows the taking edge
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dfirst <= 1'b0;
		end else begin
			dfirst <= take;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	property p_idle_ready;
		!dph |-> hreadyout_o && !hresp_o;
	endproperty
	a_idle_ready: assert property (p_idle_ready) else $error("slave not ready outside transfer");
	property p_wr_fast;
		dfirst && dwr && !busy_o |-> hreadyout_o;
	endproperty
	a_wr_fast: assert property (p_wr_fast) else $error("idle write stalled");
	property p_rd_wait;
		// after a busy first cycle the load cycle still stalls, else data is ready
		dfirst && !dwr |-> !hreadyout_o ##1 (hreadyout_o == !$past(busy_o));
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_busy_stall;
		dph && busy_o |-> !hreadyout_o;
	endproperty
	a_busy_stall: assert property (p_busy_stall) else $error("transfer done while busy");
	property p_busy_bound;
		$rose(busy_o) |-> ##[1:2] !busy_o;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("operation too long");
	property p_busy_cause;
		$rose(busy_o) |-> $past(commit);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
	property p_slot_quiet;
		busy_o && $past(busy_o) |=> $stable(pc_o) && $stable(acc_o);
	endproperty
	a_slot_quiet: assert property (p_slot_quiet) else $error("idle slot changed state");
	property p_acc_cause;
		$changed(acc_o) |-> $past(busy_o) || $past(commit);
	endproperty
	a_acc_cause: assert property (p_acc_cause) else $error("accumulator changed alone");
	property p_pc_cause;
		$changed(pc_o) |-> $past(busy_o) || $past(commit);
	endproperty
	a_pc_cause: assert property (p_pc_cause) else $error("pc changed alone");
	c_slot: cover property (busy_o ##1 busy_o);
	c_read: cover property (dfirst && !dwr);
	c_stall: cover property (dph && busy_o);
endmodule

bind increment_or_shift_branch_ops increment_or_shift_branch_ops_monitor mon (.core_clk_i,
	.rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
	.hrdata_o, .hreadyout_o, .hresp_o, .pc_o, .acc_o, .busy_o);
